// *** logic/wtc_regs.sv ***
`include "wtc_defines.svh"
module wtc_regs #(
   parameter int TICK_CYCLES = `WTC_TICK_NS / `WTC_CLK_NS
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  soft_reset,
   input  wire logic                  sclk_pin,
   input  wire logic                  serial_chip_select_n,
   input  wire logic                  mosi_pin,
   input  wire wtc_pkg::wtc_mode_type mode,
   input  wire logic                  hv_wake_pin,
   input  wire logic                  general_pin,
   input  wire logic                  wake_source_event,
   input  wire logic                  other_status_event,
   output logic                       sdo_q,
   output logic                       sdo_oe_n_q,
   output logic                       hv_wake_enable_q,
   output logic                       voltage_sense_active_q,
   output logic                       wake_pin_level_status_q,
   output logic                       general_pin_level_status_q,
   output logic [1:0]                 wake_pin_pull_select_q,
   output logic [1:0]                 general_pin_pull_select_q,
   output logic                       can_wake_capable_q,
   output logic                       can_flash_q,
   output logic                       high_side_switch_output_q,
   output logic                       cyclic_wake_event_q,
   output logic                       cyclic_sense_sample_q,
   output logic                       spi_fail_q,
   output logic                       interrupt_output_n_q
);
   import wtc_pkg::*;

   wtc_frame_type     frame;
   wtc_tmr_state_type tmr_state_q;
   logic              frame_valid;
   logic              frame_error;
   logic [6:0]        rd_addr;
   logic [7:0]        rd_data;
   logic [7:0]        bus_ctrl0_q;
   logic [7:0]        ext_wake_q;
   logic [7:0]        wake_pull_q;
   logic [7:0]        bus_ctrl3_q;
   logic [7:0]        timer_q;
   logic [1:0]        wake_lvl_s_q;
   logic [1:0]        gen_lvl_s_q;
   logic              fs_mode_q;
   logic              rs_mode_q;
   logic              fs_entry;
   logic              rs_entry;
   logic              wr_hit;
   logic              meas_sel;
   logic              meas_ignores;
   logic              meas_refused;
   logic              status_read;
   logic              tmr_clear;
   logic [13:0]       tick_cnt_q;
   logic              tick;
   logic [23:0]       tmr_cnt_q;
   logic [2:0]        on_code;
   logic              on_runs;
   logic              assigned;

   // Register contents as seen by a read; reserved bits are zero
   function automatic logic [7:0] read_mux(input logic [6:0] a);
      unique case (a)
         `WTC_ADDR_BUS_CTRL0:  read_mux = bus_ctrl0_q & `WTC_MASK_BUS_CTRL0; //RULE_21
         `WTC_ADDR_EXT_WAKE:   read_mux = ext_wake_q & `WTC_MASK_EXT_WAKE;
         `WTC_ADDR_WAKE_PULL:  read_mux = wake_pull_q & `WTC_MASK_WAKE_PULL;
         `WTC_ADDR_BUS_CTRL3:  read_mux = bus_ctrl3_q & `WTC_MASK_BUS_CTRL3;
         `WTC_ADDR_TIMER:      read_mux = timer_q & `WTC_MASK_TIMER;
         `WTC_ADDR_SPI_STATUS: read_mux = {7'h00, spi_fail_q};
         default:              read_mux = 8'h00;
      endcase
   endfunction

   // On-time in 100 us ticks: 0.1, 0.3, 1.0, 10, 20 ms
   function automatic logic [23:0] on_ticks(input logic [2:0] c);
      unique case (c)
         3'h1:    on_ticks = 24'h000001; //RULE_12
         3'h2:    on_ticks = 24'h000003;
         3'h3:    on_ticks = 24'h00000A;
         3'h4:    on_ticks = 24'h000064;
         3'h5:    on_ticks = 24'h0000C8;
         default: on_ticks = 24'h000000;
      endcase
   endfunction

   // Period in 100 us ticks, 10 ms up to 1000 s
   function automatic logic [23:0] per_ticks(input logic [3:0] c);
      unique case (c)
         4'h0: per_ticks = 24'h000064; //RULE_13
         4'h1: per_ticks = 24'h0000C8;
         4'h2: per_ticks = 24'h0001F4;
         4'h3: per_ticks = 24'h0003E8;
         4'h4: per_ticks = 24'h0007D0;
         4'h5: per_ticks = 24'h001388;
         4'h6: per_ticks = 24'h002710;
         4'h7: per_ticks = 24'h004E20;
         4'h8: per_ticks = 24'h00C350;
         4'h9: per_ticks = 24'h0186A0;
         4'hA: per_ticks = 24'h030D40;
         4'hB: per_ticks = 24'h07A120;
         4'hC: per_ticks = 24'h0F4240;
         4'hD: per_ticks = 24'h1E8480;
         4'hE: per_ticks = 24'h4C4B40;
         4'hF: per_ticks = 24'h989680;
      endcase
   endfunction

   wtc_spi_slave u_spi (
      .clock       (clock),
      .rst         (rst),
      .sclk_pin    (sclk_pin),
      .csn_pin     (serial_chip_select_n),
      .mosi_pin    (mosi_pin),
      .rd_data     (rd_data),
      .status_byte ({7'h00, spi_fail_q}),
      .rd_addr     (rd_addr),
      .frame       (frame),
      .frame_valid (frame_valid),
      .frame_error (frame_error),
      .sdo_q       (sdo_q),
      .sdo_oe_n_q  (sdo_oe_n_q)
   );

   assign rd_data = read_mux(rd_addr);

   // Mode entry edges; mode levels come from same-clock logic
   always_ff @(posedge clock) begin
      if (rst) begin
         fs_mode_q <= 1'b0;
         rs_mode_q <= 1'b0;
      end else begin
         fs_mode_q <= mode.fail_safe_mode;
         rs_mode_q <= mode.restart_mode;
      end
   end

   assign fs_entry     = mode.fail_safe_mode & ~fs_mode_q;
   assign rs_entry     = mode.restart_mode & ~rs_mode_q;
   assign wr_hit       = frame_valid & frame.wr; //RULE_17
   assign meas_sel     = ext_wake_q[`WTC_BIT_MEAS];
   assign meas_ignores = meas_sel & ~mode.fail_output_active; //RULE_03
   assign meas_refused = wr_hit && frame.addr == `WTC_ADDR_EXT_WAKE
                         && frame.data[`WTC_BIT_MEAS] && mode.fail_output_active; //RULE_04
   assign status_read  = frame_valid && !frame.wr && frame.addr == `WTC_ADDR_SPI_STATUS;

   // Transceiver mode; only the mode field is stored
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         bus_ctrl0_q <= `WTC_RST_BUS_CTRL0;
      end else if (wr_hit && frame.addr == `WTC_ADDR_BUS_CTRL0) begin
         bus_ctrl0_q <= frame.data & `WTC_MASK_BUS_CTRL0; //RULE_23
      end
   end

   // External wake control: fail-safe forcing beats a write
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         ext_wake_q <= `WTC_RST_EXT_WAKE; //RULE_02
      end else if (fs_entry && !meas_sel) begin
         ext_wake_q <= (ext_wake_q & `WTC_FS_KEEP) | `WTC_FS_EXT_WAKE; //RULE_07
      end else if (wr_hit && frame.addr == `WTC_ADDR_EXT_WAKE) begin
         ext_wake_q <= frame.data & `WTC_MASK_EXT_WAKE;
         if (meas_refused) begin
            ext_wake_q[`WTC_BIT_MEAS] <= meas_sel; //RULE_04
         end
      end
   end

   // Pull fields survive restart, reserved bits never stored
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         wake_pull_q <= `WTC_RST_WAKE_PULL;
      end else if (rs_entry) begin
         wake_pull_q <= wake_pull_q & `WTC_KEEP_WAKE_PULL; //RULE_20
      end else if (wr_hit && frame.addr == `WTC_ADDR_WAKE_PULL) begin
         wake_pull_q <= frame.data & `WTC_MASK_WAKE_PULL; //RULE_23
      end
   end

   // Flash bit survives restart
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         bus_ctrl3_q <= `WTC_RST_BUS_CTRL3;
      end else if (rs_entry) begin
         bus_ctrl3_q <= bus_ctrl3_q & `WTC_KEEP_BUS_CTRL3; //RULE_19
      end else if (wr_hit && frame.addr == `WTC_ADDR_BUS_CTRL3) begin
         bus_ctrl3_q <= frame.data & `WTC_MASK_BUS_CTRL3; //RULE_11
      end
   end

   // Cleared switch in restart would give false sensing, so clear it
   assign tmr_clear = rs_entry | (mode.restart_mode & mode.cyclic_sense_sel
                                  & mode.hs_switch_cleared); //RULE_15

   always_ff @(posedge clock) begin
      if (rst || soft_reset || tmr_clear) begin
         timer_q <= `WTC_RST_TIMER; //RULE_18
      end else if (wr_hit && frame.addr == `WTC_ADDR_TIMER) begin
         timer_q <= frame.data & `WTC_MASK_TIMER;
      end
   end

   // Set wins over the clear by a status read
   always_ff @(posedge clock) begin
      if (rst || soft_reset) begin
         spi_fail_q <= 1'b0;
      end else if (meas_refused || frame_error) begin
         spi_fail_q <= 1'b1; //RULE_04
      end else if (status_read) begin
         spi_fail_q <= 1'b0;
      end
   end

   // Effective configuration seen by the pins and the transceiver
   always_ff @(posedge clock) begin
      if (rst) begin
         hv_wake_enable_q          <= 1'b0;
         voltage_sense_active_q    <= 1'b0;
         wake_pin_pull_select_q    <= 2'h0;
         general_pin_pull_select_q <= 2'h0;
         can_wake_capable_q        <= 1'b0;
         can_flash_q               <= 1'b0;
      end else begin
         hv_wake_enable_q <= ext_wake_q[`WTC_BIT_WAKE_EN] & ~meas_ignores
                             & ~(meas_sel & mode.fail_safe_mode); //RULE_01 RULE_08
         voltage_sense_active_q    <= meas_sel & mode.normal_mode; //RULE_05
         wake_pin_pull_select_q    <= wake_pull_q[1:0]; //RULE_10
         general_pin_pull_select_q <= meas_ignores ? 2'h0 : wake_pull_q[7:6]; //RULE_09
         can_wake_capable_q <= bus_ctrl0_q[1:0] == `WTC_CAN_WAKE_CAP; //RULE_06
         can_flash_q        <= bus_ctrl3_q[`WTC_BIT_FLASH]; //RULE_11
      end
   end

   // Pin levels: two flops, then held at zero while sensing
   always_ff @(posedge clock) begin
      if (rst) begin
         wake_lvl_s_q               <= 2'h0;
         gen_lvl_s_q                <= 2'h0;
         wake_pin_level_status_q    <= 1'b0;
         general_pin_level_status_q <= 1'b0;
      end else begin
         wake_lvl_s_q <= {wake_lvl_s_q[0], hv_wake_pin};
         gen_lvl_s_q  <= {gen_lvl_s_q[0], general_pin};
         wake_pin_level_status_q    <= ~meas_sel & wake_lvl_s_q[1]; //RULE_05
         general_pin_level_status_q <= ~meas_sel & gen_lvl_s_q[1];
      end
   end

   // Global bit lets every status event reach the interrupt pin
   always_ff @(posedge clock) begin
      if (rst) begin
         interrupt_output_n_q <= 1'b1;
      end else begin
         interrupt_output_n_q <= ~(wake_source_event
            | (ext_wake_q[`WTC_BIT_INT_GLOBAL] & other_status_event)); //RULE_22
      end
   end

   // 100 us base tick keeps the 1000 s period within 24 bits
   always_ff @(posedge clock) begin
      if (rst || tick) begin
         tick_cnt_q <= 14'h0000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 14'h0001;
      end
   end
   assign tick = tick_cnt_q == 14'(TICK_CYCLES - 1);

   assign on_code  = timer_q[6:4];
   assign on_runs  = on_code != `WTC_ON_STOP_LOW && on_code != `WTC_ON_STOP_HIGH
                     && on_code != `WTC_ON_RESERVED;
   assign assigned = mode.timer_wake_source | mode.cyclic_sense_sel;

   // Timer: a committed write to the timer register restarts the period from its on-phase
   always_ff @(posedge clock) begin
      if (rst || !(assigned && on_runs) || (wr_hit && frame.addr == `WTC_ADDR_TIMER)) begin
         tmr_state_q <= TMR_STOP;
         tmr_cnt_q   <= 24'h000000;
      end else begin
         unique case (tmr_state_q)
            TMR_STOP: begin
               tmr_state_q <= TMR_ON; //RULE_14
               tmr_cnt_q   <= 24'h000000;
            end
            TMR_ON: if (tick) begin
               tmr_cnt_q <= tmr_cnt_q + 24'h000001;
               if (tmr_cnt_q + 24'h000001 >= on_ticks(on_code)) begin
                  tmr_state_q <= TMR_OFF;
               end
            end
            TMR_OFF: if (tick) begin
               if (tmr_cnt_q + 24'h000001 >= per_ticks(timer_q[3:0])) begin
                  tmr_state_q <= TMR_ON;
                  tmr_cnt_q   <= 24'h000000;
               end else begin
                  tmr_cnt_q <= tmr_cnt_q + 24'h000001;
               end
            end
            default: tmr_state_q <= TMR_STOP;
         endcase
      end
   end

   // Switch output and the two cyclic events, which never fire in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         high_side_switch_output_q <= 1'b0;
         cyclic_wake_event_q       <= 1'b0;
         cyclic_sense_sample_q     <= 1'b0;
      end else begin
         high_side_switch_output_q <= (tmr_state_q == TMR_ON)
            || (on_code == `WTC_ON_STOP_HIGH); //RULE_12
         cyclic_wake_event_q <= mode.timer_wake_source && assigned && on_runs //RULE_16
            && (tmr_state_q == TMR_STOP || (tmr_state_q == TMR_OFF && tick
            && tmr_cnt_q + 24'h000001 >= per_ticks(timer_q[3:0]))); // Every period start
         cyclic_sense_sample_q <= mode.cyclic_sense_sel && tmr_state_q == TMR_ON
            && tick && tmr_cnt_q + 24'h000001 >= on_ticks(on_code); //RULE_16
      end
   end

   default clocking dc @(posedge clock); endclocking
   default disable iff (rst);

   sequence refused_write_s;
      meas_refused && !soft_reset && !fs_entry;
   endsequence

   meas_refuse_a: assert property (refused_write_s |=> spi_fail_q && $stable(meas_sel)) //RULE_04
      else $error("sensing write not refused");
   fs_force_a: assert property (fs_entry && !meas_sel && !soft_reset //RULE_07
      |=> ext_wake_q[4:0] == 5'h01 && !ext_wake_q[6])
      else $error("fail-safe pattern missing");
   level_freeze_a: assert property (meas_sel |=> !wake_pin_level_status_q //RULE_05
      && !general_pin_level_status_q)
      else $error("wake level updated while sensing");
   timer_clear_a: assert property (rs_entry |=> timer_q == 8'h00) //RULE_18
      else $error("timer not cleared on restart");
   flash_keep_a: assert property (rs_entry && !soft_reset //RULE_19
      |=> bus_ctrl3_q == ($past(bus_ctrl3_q) & 8'h10))
      else $error("flash bit lost on restart");
   pull_keep_a: assert property (rs_entry && !soft_reset //RULE_20
      |=> wake_pull_q == ($past(wake_pull_q) & 8'hC3))
      else $error("pull fields lost on restart");
   reserved_zero_a: assert property ((wake_pull_q & 8'h3C) == 8'h00 //RULE_21
      && (bus_ctrl3_q & 8'hEF) == 8'h00 && (bus_ctrl0_q & 8'hF8) == 8'h00
      && (timer_q[7] == 1'b0) && (ext_wake_q & 8'h5E) == 8'h00)
      else $error("reserved bit set");
   stop_high_a: assert property (on_code == 3'h6 |=> high_side_switch_output_q) //RULE_12
      else $error("stop-high code not driving high");
   start_run_a: assert property (tmr_state_q == TMR_STOP && assigned && on_runs //RULE_14
      && !wr_hit |=> tmr_state_q == TMR_ON ##1 high_side_switch_output_q)
      else $error("timer did not start");
   ignore_wake_a: assert property (meas_ignores |=> !hv_wake_enable_q) //RULE_03
      else $error("wake enable not ignored");
endmodule

// *** logic/wtc_defines.svh ***
`ifndef WTC_DEFINES_SVH
`define WTC_DEFINES_SVH
// Contract
// RULE_01: Wake enable bit gates wake pin source
// RULE_02: Default selection is static wake sensing
// RULE_03: Sensing without fail output ignores wake config
// RULE_04: Sensing write refused under fail output
// RULE_05: Sensing clears, freezes both level status bits
// RULE_06: Transceiver mode field selects CAN wake
// RULE_07: Fail-safe entry forces wake control x0x0 0001
// RULE_08: Sensing selected: no wake pin in fail-safe
// RULE_09: Bits 7:6 set general pin pull network
// RULE_10: Bits 1:0 set wake pin pull network
// RULE_11: Bit 4 selects CAN flash mode
// RULE_12: On-time field decode, stop low/high codes
// RULE_13: Period field selects 10ms through 1000s
// RULE_14: Assigned timer starts on nonzero on-time
// RULE_15: Restart with sense, switch cleared clears timer
// RULE_16: Cyclic sense and wake run together
// RULE_17: New settings act at chip-select rise
// RULE_18: Timer register zero after every reset kind
// RULE_19: Restart keeps only bus control three flash bit
// RULE_20: Restart keeps both pull fields only
// RULE_21: Reserved bits read back zero
// RULE_22: Global bit widens interrupt sources
// RULE_23: Reserved writes have no effect

// Register offsets (seven-bit addresses)
`define WTC_ADDR_BUS_CTRL0   7'h04
`define WTC_ADDR_EXT_WAKE    7'h07
`define WTC_ADDR_WAKE_PULL   7'h08
`define WTC_ADDR_BUS_CTRL3   7'h0B
`define WTC_ADDR_TIMER       7'h0C
`define WTC_ADDR_SPI_STATUS  7'h1F
// Writable bit masks
`define WTC_MASK_BUS_CTRL0   8'h07
`define WTC_MASK_EXT_WAKE    8'hA1
`define WTC_MASK_WAKE_PULL   8'hC3
`define WTC_MASK_BUS_CTRL3   8'h10
`define WTC_MASK_TIMER       8'h7F
// Restart keep masks
`define WTC_KEEP_WAKE_PULL   8'hC3
`define WTC_KEEP_BUS_CTRL3   8'h10
// Field positions
`define WTC_BIT_WAKE_EN      0
`define WTC_BIT_MEAS         5
`define WTC_BIT_INT_GLOBAL   7
`define WTC_BIT_FLASH        4
// Reset values
`define WTC_RST_BUS_CTRL0    8'h00
`define WTC_RST_EXT_WAKE     8'h01
`define WTC_RST_WAKE_PULL    8'h00
`define WTC_RST_BUS_CTRL3    8'h00
`define WTC_RST_TIMER        8'h00
// Fail-safe wake control pattern, bits 7 and 5 kept
`define WTC_FS_EXT_WAKE      8'h01
`define WTC_FS_KEEP          8'hA0
// On-time codes
`define WTC_ON_STOP_LOW      3'h0
`define WTC_ON_STOP_HIGH     3'h6
`define WTC_ON_RESERVED      3'h7
// CAN wake-capable mode, low two bits
`define WTC_CAN_WAKE_CAP     2'h1
// Timer tick: 100 us base at 8 ns clock
`define WTC_TICK_NS          100000
`define WTC_CLK_NS           8
`define WTC_FRAME_BITS       5'h10
`endif

// *** logic/wtc_pkg.sv ***
package wtc_pkg;
   // One decoded serial frame
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } wtc_frame_type;

   // Mode levels and selections from the rest of the chip
   typedef struct packed {
      logic fail_output_active;
      logic fail_safe_mode;
      logic restart_mode;
      logic normal_mode;
      logic cyclic_sense_sel;
      logic hs_switch_cleared;
      logic timer_wake_source;
   } wtc_mode_type;

   typedef enum logic [1:0] {
      TMR_STOP = 2'b00,
      TMR_ON   = 2'b01,
      TMR_OFF  = 2'b10
   } wtc_tmr_state_type;
endpackage

// *** logic/wtc_spi_slave.sv ***
`include "wtc_defines.svh"
module wtc_spi_slave (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  sclk_pin,
   input  wire logic                  csn_pin,
   input  wire logic                  mosi_pin,
   input  wire logic [7:0]            rd_data,
   input  wire logic [7:0]            status_byte,
   output logic [6:0]                 rd_addr,
   output wtc_pkg::wtc_frame_type     frame,
   output logic                       frame_valid,
   output logic                       frame_error,
   output logic                       sdo_q,
   output logic                       sdo_oe_n_q
);
   import wtc_pkg::*;

   logic [2:0]  sclk_s_q;
   logic [2:0]  csn_s_q;
   logic [1:0]  mosi_s_q;
   logic [15:0] rx_q;
   logic [7:0]  tx_q;
   logic [4:0]  cnt_q;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_fall;
   logic        cs_rise;

   // Two-stage synchronisers; edges from stages two and three only
   always_ff @(posedge clock) begin
      if (rst) begin
         sclk_s_q <= 3'h0;
         csn_s_q  <= 3'h7;
         mosi_s_q <= 2'h0;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
         csn_s_q  <= {csn_s_q[1:0], csn_pin};
         mosi_s_q <= {mosi_s_q[0], mosi_pin};
      end
   end

   assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2] & ~csn_s_q[1];
   assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2] & ~csn_s_q[1];
   assign cs_fall   = ~csn_s_q[1] & csn_s_q[2];
   assign cs_rise   = csn_s_q[1] & ~csn_s_q[2];
   assign rd_addr   = rx_q[14:8];

   // Receive, LSB first; address then write flag then data
   always_ff @(posedge clock) begin
      if (rst || cs_fall) begin
         rx_q  <= 16'h0000;
         cnt_q <= 5'h00;
      end else if (sclk_rise) begin
         rx_q  <= {mosi_s_q[1], rx_q[15:1]};
         cnt_q <= (cnt_q == 5'h1F) ? cnt_q : cnt_q + 5'h01;
      end
   end

   // Frame ends at chip-select rise; a wrong bit count is an error
   always_ff @(posedge clock) begin
      if (rst) begin
         frame       <= '0;
         frame_valid <= 1'b0;
         frame_error <= 1'b0;
      end else begin
         frame       <= '{wr: rx_q[7], addr: rx_q[6:0], data: rx_q[15:8]};
         frame_valid <= cs_rise && (cnt_q == `WTC_FRAME_BITS);
         frame_error <= cs_rise && (cnt_q != `WTC_FRAME_BITS);
      end
   end

   // Status byte goes out first, then the addressed register
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_q       <= 8'h00;
         sdo_q      <= 1'b0;
         sdo_oe_n_q <= 1'b1;
      end else begin
         sdo_oe_n_q <= csn_s_q[1];
         if (cs_fall) begin
            sdo_q <= status_byte[0];
            tx_q  <= {1'b0, status_byte[7:1]};
         end else if (sclk_fall && cnt_q == 5'h08) begin
            sdo_q <= rd_data[0];
            tx_q  <= {1'b0, rd_data[7:1]};
         end else if (sclk_fall) begin
            sdo_q <= tx_q[0];
            tx_q  <= {1'b0, tx_q[7:1]};
         end
      end
   end
endmodule

// *** tb/wtc_host_model.sv ***
// Host side serial master, mode 0, LSB first
module wtc_host_model (
   input  wire logic clock,
   input  wire logic sdo,
   output logic      sclk,
   output logic      csn_n,
   output logic      mosi
);
   timeunit 1ns;
   timeprecision 100ps;
   // Link clock stands low between frames
   initial begin
      sclk = 1'b0;
      csn_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One whole 16-bit frame; SCLK half period of 10 clocks gives 80 ns
   task automatic xfer(input logic [15:0] f, output logic [15:0] r);
      csn_n = 1'b0;
      tk(10);
      for (int i = 0; i < 16; i++) begin
         mosi = f[i];
         tk(10);
         sclk = 1'b1;
         r[i] = sdo; // Status then register, bit by bit
         tk(10);
         sclk = 1'b0;
      end
      mosi = ~mosi; // Stale data must not look valid
      tk(10);
      csn_n = 1'b1;
      tk(12);
   endtask
endmodule

// *** tb/wtc_regs_tb.sv ***
module wtc_regs_tb;
   import wtc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, rst = 1, soft_reset = 0, hv_wake_pin = 1, general_pin = 1;
   logic wake_source_event = 0, other_status_event = 0, sclk_pin, csn_n, mosi_pin;
   wtc_mode_type mode = '0;
   logic sdo_q, sdo_oe_n_q, hv_wake_enable_q, voltage_sense_active_q, spi_fail_q;
   logic wake_pin_level_status_q, general_pin_level_status_q, can_wake_capable_q;
   logic [1:0] wake_pin_pull_select_q, general_pin_pull_select_q;
   logic can_flash_q, high_side_switch_output_q, cyclic_wake_event_q;
   logic cyclic_sense_sample_q, interrupt_output_n_q;
   int error_cnt = 0, samples_checked = 0, n, m;
   // Free running 125 MHz clock
   initial forever #4 clock = ~clock;
   // Short tick keeps the timer periods inside the run
   wtc_regs #(.TICK_CYCLES(4)) uut (
      .clock, .rst, .soft_reset, .sclk_pin, .serial_chip_select_n(csn_n), .mosi_pin,
      .mode, .hv_wake_pin, .general_pin, .wake_source_event, .other_status_event,
      .sdo_q, .sdo_oe_n_q, .hv_wake_enable_q, .voltage_sense_active_q,
      .wake_pin_level_status_q, .general_pin_level_status_q, .wake_pin_pull_select_q,
      .general_pin_pull_select_q, .can_wake_capable_q, .can_flash_q,
      .high_side_switch_output_q, .cyclic_wake_event_q, .cyclic_sense_sample_q,
      .spi_fail_q, .interrupt_output_n_q
   );
   wtc_host_model host (.clock, .sdo(sdo_q), .sclk(sclk_pin), .csn_n, .mosi(mosi_pin));
   task automatic tk(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle status events, interrupt pin looked at the edge after
   task automatic ev(input logic w, input logic o, input logic [7:0] exp);
      wake_source_event = w;
      other_status_event = o;
      tk(1);
      wake_source_event = 0;
      other_status_event = 0;
      chk(interrupt_output_n_q, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      host.xfer({d, 1'b1, a}, r);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      logic [15:0] r;
      host.xfer({8'h00, 1'b0, a}, r);
      chk(r[15:8], exp);
   endtask
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge clock);
      error_cnt++;
      end_sim();
   end
   // Main sequence
   initial begin
      tk(10);
      rst = 0;
      tk(4);
      rd(7'h08, 8'h00);
      rd(7'h0B, 8'h00);
      rd(7'h0C, 8'h00);
      rd(7'h07, 8'h01);
      chk(hv_wake_enable_q, 8'h01);
      chk(8'({wake_pin_level_status_q, general_pin_level_status_q}), 8'h03);
      chk(sdo_oe_n_q, 8'h01);
      $display("reset values done");
      wr(7'h08, 8'hFF);
      rd(7'h08, 8'hC3);
      chk(8'({wake_pin_pull_select_q, general_pin_pull_select_q}), 8'h0F);
      wr(7'h08, 8'h42);
      chk(8'({wake_pin_pull_select_q, general_pin_pull_select_q}), 8'h09);
      wr(7'h0B, 8'hFF);
      rd(7'h0B, 8'h10);
      chk(can_flash_q, 8'h01);
      wr(7'h04, 8'h01);
      chk(can_wake_capable_q, 8'h01);
      wr(7'h0C, 8'hE0);
      rd(7'h0C, 8'h60);
      chk(high_side_switch_output_q, 8'h01);
      wr(7'h0C, 8'h00);
      chk(high_side_switch_output_q, 8'h00);
      rd(7'h10, 8'h00);
      $display("field writes done");
      mode.timer_wake_source = 1;
      mode.cyclic_sense_sel = 1;
      wr(7'h0C, 8'h10);
      n = 0;
      m = 0;
      // First period start falls inside the write; the window holds one more
      repeat (500) begin
         tk(1);
         if (cyclic_wake_event_q === 1'b1) n++;
         if (cyclic_sense_sample_q === 1'b1) m++;
      end
      chk(8'(n), 8'h01);
      chk(8'(m), 8'h01);
      mode.restart_mode = 1;
      tk(3);
      mode.restart_mode = 0;
      tk(3);
      rd(7'h08, 8'h42);
      rd(7'h0B, 8'h10);
      rd(7'h0C, 8'h00);
      mode = '0;
      mode.restart_mode = 1;
      mode.cyclic_sense_sel = 1;
      mode.hs_switch_cleared = 1;
      wr(7'h0C, 8'h15);
      rd(7'h0C, 8'h00);
      mode = '0;
      $display("timer and restart done");
      soft_reset = 1;
      tk(1);
      soft_reset = 0;
      tk(4);
      rd(7'h08, 8'h00);
      rd(7'h0B, 8'h00);
      ev(0, 1, 8'h01);
      ev(1, 0, 8'h00);
      mode.fail_output_active = 1;
      wr(7'h07, 8'h21);
      rd(7'h07, 8'h01);
      chk(spi_fail_q, 8'h01);
      rd(7'h1F, 8'h01);
      rd(7'h1F, 8'h00);
      mode.fail_output_active = 0;
      wr(7'h08, 8'hC3);
      mode.normal_mode = 1;
      wr(7'h07, 8'h21);
      chk(voltage_sense_active_q, 8'h01);
      chk(8'({wake_pin_level_status_q, general_pin_level_status_q}), 8'h00);
      chk(general_pin_pull_select_q, 8'h00);
      mode.fail_safe_mode = 1;
      tk(4);
      chk(hv_wake_enable_q, 8'h00);
      mode = '0;
      wr(7'h07, 8'h80);
      chk(hv_wake_enable_q, 8'h00);
      mode.fail_safe_mode = 1;
      tk(6);
      rd(7'h07, 8'h81);
      chk(hv_wake_enable_q, 8'h01);
      ev(0, 1, 8'h00);
      $display("wake control done");
      end_sim();
   end
endmodule
